/* File: design/cfil_pkg.sv */
// Constants for the CAN FIFO interrupt enable and status block.
// Assumes a 32-bit APB register bus clocked by mclk at 20 MHz.
package cfil_pkg;

   // =======================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_ENABLE_STATUS = 8'h00;
   localparam logic [7:0] OFS_EVENT_STATUS  = 8'h04;
   localparam logic [7:0] OFS_EVENT_MASK    = 8'h08;
   localparam logic [7:0] OFS_LIVE_COND     = 8'h0c;

   // =======================================================
   // Field positions in the enable and status register
   localparam int BIT_TX_NOT_FULL_EN = 26;
   localparam int BIT_TX_HALF_EN     = 25;
   localparam int BIT_TX_DRAINED_EN  = 24;
   localparam int BIT_RX_OVERRUN_EN  = 19;
   localparam int BIT_RX_FULL_EN     = 18;
   localparam int BIT_RX_HALF_EN     = 17;
   localparam int BIT_RX_HAS_DATA_EN = 16;
   localparam int BIT_TX_NOT_FULL_FL = 10;

   // =======================================================
   // Condition vector index (7 conditions)
   localparam int NUM_COND        = 7;
   localparam int IX_RX_HAS_DATA  = 0;
   localparam int IX_RX_HALF      = 1;
   localparam int IX_RX_FULL      = 2;
   localparam int IX_RX_OVERRUN   = 3;
   localparam int IX_TX_DRAINED   = 4;
   localparam int IX_TX_HALF      = 5;
   localparam int IX_TX_NOT_FULL  = 6;

   // =======================================================
   // Masks and reset values
   localparam logic [31:0] ENABLE_WR_MASK    = 32'h070f0000;
   localparam logic [31:0] ENABLE_RESET      = 32'h00000000;
   localparam logic [6:0]  COND_RESET        = 7'h00;
   localparam logic [31:0] RDATA_RESET       = 32'h00000000;

   // =======================================================
   // APB slave phases, Gray coded along idle, setup, access
   typedef enum logic [1:0] {
      CFIL_IDLE   = 2'b00,
      CFIL_SETUP  = 2'b01,
      CFIL_ACCESS = 2'b11
   } cfil_apb_state_t;

endpackage

/* File: design/cfil_cond_gen.sv */
// Condition builder: turns FIFO fill signals and direction into seven condition levels.
// Assumes fill signals are synchronous to mclk and come from the FIFO core.
`timescale 1ns/10ps
module cfil_cond_gen (
   // FIFO state
   input  wire logic       fifo_direction_transmit,
   input  wire logic       fifo_full,
   input  wire logic       fifo_half,
   input  wire logic       fifo_empty,
   input  wire logic       overrun_seen,
   // Conditions
   output logic [6:0]      cond
);

   // =======================================================
   // Transmit conditions exist only in transmit direction
   wire tx_dir = fifo_direction_transmit;
   wire rx_dir = ~fifo_direction_transmit;

   assign cond[cfil_pkg::IX_TX_NOT_FULL] = tx_dir & ~fifo_full;
   assign cond[cfil_pkg::IX_TX_HALF]     = tx_dir & fifo_half;
   assign cond[cfil_pkg::IX_TX_DRAINED]  = tx_dir & fifo_empty;

   // =======================================================
   // Receive conditions
   assign cond[cfil_pkg::IX_RX_OVERRUN]  = rx_dir & overrun_seen;
   assign cond[cfil_pkg::IX_RX_FULL]     = rx_dir & fifo_full;
   assign cond[cfil_pkg::IX_RX_HALF]     = rx_dir & fifo_half;
   assign cond[cfil_pkg::IX_RX_HAS_DATA] = rx_dir & ~fifo_empty;

endmodule // cfil_cond_gen

/* File: design/cfil_event_catch.sv */
// Sticky event catcher: a rising condition sets its bit, write-one clears it.
// Assumes a synchronous active-low reset and conditions synchronous to mclk.
`timescale 1ns/10ps
module cfil_event_catch (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_n,
   // Conditions and clear strobes
   input  wire logic [6:0] cond,
   input  wire logic [6:0] clear,
   // Sticky bits
   output logic [6:0]      sticky
);

   logic [6:0] prev_reg;
   logic [6:0] sticky_reg;

   // =======================================================
   // One catcher per condition; a set in the clear cycle wins
   genvar i;
   generate
      for (i = 0; i < cfil_pkg::NUM_COND; i = i + 1) begin : g_bit
         wire rise       = cond[i] & ~prev_reg[i];
         wire bit_next   = rise | (sticky_reg[i] & ~clear[i]);
         always_ff @(posedge mclk) begin
            if (!rst_n) begin
               prev_reg[i]   <= 1'b0;
               sticky_reg[i] <= 1'b0;
            end else begin
               prev_reg[i]   <= cond[i];
               sticky_reg[i] <= bit_next;
            end
         end
      end
   endgenerate

   assign sticky = sticky_reg;

endmodule // cfil_event_catch

/* File: design/cfil_fifo_irq.sv */
// FIFO interrupt enable and status register with APB slave and two interrupt outputs.
// Assumes one mclk domain, synchronous reset, and FIFO signals synchronous to mclk.
//
// Function
// - Bit 26 is a writable enable that lets the transmit not-full condition interrupt.
// - Bit 25 is a writable enable that lets the transmit half-full condition interrupt.
// - Bit 24 is a writable enable that lets the transmit empty condition interrupt.
// - Bit 19 is a writable enable that lets a receive overflow event interrupt.
// - Bit 18 is a writable enable that lets the receive full condition interrupt.
// - Bit 17 is a writable enable that lets the receive half-full condition interrupt.
// - Bit 16 is a writable enable that lets a non-empty receive FIFO interrupt.
// - In transmit direction bit 10 reads one while space is left and zero when full.
// - In receive direction bit 10 is unused and reads zero.
// - Bit 10 ignores writes and follows the live fill state, never latching.
// - Bits 31-27, 23-20 and 15-11 read zero and ignore writes.
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
module cfil_fifo_irq (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // FIFO core
   input  wire logic        fifo_direction_transmit,
   input  wire logic        fifo_full,
   input  wire logic        fifo_half,
   input  wire logic        fifo_empty,
   input  wire logic        fifo_overflow,
   // Interrupts
   output logic             fifo_irq,
   output logic             irq
);

   // =======================================================
   // Storage
   cfil_pkg::cfil_apb_state_t state_reg;
   cfil_pkg::cfil_apb_state_t state_next;

   logic [31:0] enable_reg;
   logic [31:0] enable_next;
   logic [6:0]  mask_reg;
   logic [6:0]  mask_next;
   logic        overrun_seen_reg;
   logic        overrun_seen_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic        pslverr_reg;
   logic        pslverr_next;

   // =======================================================
   // Condition and event nets
   logic [6:0]  cond;
   logic [6:0]  sticky;
   logic [6:0]  clear;
   logic [6:0]  irq_en;

   // =======================================================
   // APB phase tracking
   wire setup_phase  = psel & ~penable;
   wire access_phase = psel & penable;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         cfil_pkg::CFIL_IDLE: begin
            if (setup_phase) begin
               state_next = cfil_pkg::CFIL_SETUP;
            end
         end
         cfil_pkg::CFIL_SETUP: begin
            if (access_phase) begin
               state_next = cfil_pkg::CFIL_ACCESS;
            end else if (!psel) begin
               state_next = cfil_pkg::CFIL_IDLE;
            end
         end
         cfil_pkg::CFIL_ACCESS: begin
            if (setup_phase) begin
               state_next = cfil_pkg::CFIL_SETUP;
            end else begin
               state_next = cfil_pkg::CFIL_IDLE;
            end
         end
         default: begin
            state_next = cfil_pkg::CFIL_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_reg <= cfil_pkg::CFIL_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // =======================================================
   // Address decode
   wire hit_enable = (paddr == cfil_pkg::OFS_ENABLE_STATUS);
   wire hit_event  = (paddr == cfil_pkg::OFS_EVENT_STATUS);
   wire hit_mask   = (paddr == cfil_pkg::OFS_EVENT_MASK);
   wire hit_live   = (paddr == cfil_pkg::OFS_LIVE_COND);
   wire hit_any    = hit_enable | hit_event | hit_mask | hit_live;

   // Read data is captured in setup, so the access cycle answers at once
   wire capture    = setup_phase & (state_reg != cfil_pkg::CFIL_SETUP);
   wire wr_commit  = access_phase & pwrite & hit_any;

   wire wr_enable  = wr_commit & hit_enable;
   wire wr_event   = wr_commit & hit_event;
   wire wr_mask    = wr_commit & hit_mask;

   assign pready   = access_phase;
   assign pslverr  = pslverr_reg & access_phase;
   assign prdata   = prdata_reg;

   // =======================================================
   // Packing of seven-bit vectors into register layout
   function automatic logic [31:0] cfil_pack(input logic [6:0] v);
      logic [31:0] w;
      w        = 32'h00000000;
      w[26:24] = v[6:4];
      w[19:16] = v[3:0];
      return w;
   endfunction

   function automatic logic [6:0] cfil_unpack(input logic [31:0] w);
      logic [6:0] v;
      v      = 7'h00;
      v[6:4] = w[26:24];
      v[3:0] = w[19:16];
      return v;
   endfunction

   // =======================================================
   // Enable register: only the seven enable bits store data
   assign enable_next = wr_enable ? (pwdata & cfil_pkg::ENABLE_WR_MASK)
                                  : enable_reg;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         enable_reg <= cfil_pkg::ENABLE_RESET;
      end else begin
         enable_reg <= enable_next;
      end
   end

   assign irq_en[cfil_pkg::IX_TX_NOT_FULL] = enable_reg[cfil_pkg::BIT_TX_NOT_FULL_EN];
   assign irq_en[cfil_pkg::IX_TX_HALF]     = enable_reg[cfil_pkg::BIT_TX_HALF_EN];
   assign irq_en[cfil_pkg::IX_TX_DRAINED]  = enable_reg[cfil_pkg::BIT_TX_DRAINED_EN];
   assign irq_en[cfil_pkg::IX_RX_OVERRUN]  = enable_reg[cfil_pkg::BIT_RX_OVERRUN_EN];
   assign irq_en[cfil_pkg::IX_RX_FULL]     = enable_reg[cfil_pkg::BIT_RX_FULL_EN];
   assign irq_en[cfil_pkg::IX_RX_HALF]     = enable_reg[cfil_pkg::BIT_RX_HALF_EN];
   assign irq_en[cfil_pkg::IX_RX_HAS_DATA] = enable_reg[cfil_pkg::BIT_RX_HAS_DATA_EN];

   // =======================================================
   // Overflow is a pulse; hold it until software clears its event bit
   assign clear = wr_event ? cfil_unpack(pwdata) : 7'h00;

   assign overrun_seen_next = fifo_overflow
                            | (overrun_seen_reg & ~clear[cfil_pkg::IX_RX_OVERRUN]);

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         overrun_seen_reg <= 1'b0;
      end else begin
         overrun_seen_reg <= overrun_seen_next;
      end
   end

   // =======================================================
   // Live conditions from the FIFO fill state
   cfil_cond_gen u_cond (
      .fifo_direction_transmit (fifo_direction_transmit),
      .fifo_full               (fifo_full),
      .fifo_half               (fifo_half),
      .fifo_empty              (fifo_empty),
      .overrun_seen            (overrun_seen_reg),
      .cond                    (cond)
   );

   wire tx_not_full_flag = cond[cfil_pkg::IX_TX_NOT_FULL];

   // =======================================================
   // Sticky events, write one to clear
   cfil_event_catch u_catch (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .cond   (cond),
      .clear  (clear),
      .sticky (sticky)
   );

   assign mask_next = wr_mask ? cfil_unpack(pwdata) : mask_reg;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mask_reg <= cfil_pkg::COND_RESET;
      end else begin
         mask_reg <= mask_next;
      end
   end

   // =======================================================
   // Read multiplexer
   logic [31:0] enable_view;
   logic [31:0] rd_word;

   always_comb begin
      enable_view                              = enable_reg & cfil_pkg::ENABLE_WR_MASK;
      enable_view[cfil_pkg::BIT_TX_NOT_FULL_FL] = tx_not_full_flag;
   end

   always_comb begin
      rd_word = 32'h00000000;
      if (hit_enable) begin
         rd_word = enable_view;
      end else if (hit_event) begin
         rd_word = cfil_pack(sticky);
      end else if (hit_mask) begin
         rd_word = cfil_pack(mask_reg);
      end else if (hit_live) begin
         rd_word = cfil_pack(cond);
      end
   end

   assign prdata_next  = (capture && !pwrite) ? rd_word : prdata_reg;
   assign pslverr_next = capture ? ~hit_any : pslverr_reg;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         prdata_reg  <= cfil_pkg::RDATA_RESET;
         pslverr_reg <= 1'b0;
      end else begin
         prdata_reg  <= prdata_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // =======================================================
   // Interrupt outputs
   assign fifo_irq = |(cond & irq_en);
   assign irq      = |(sticky & mask_reg);

endmodule // cfil_fifo_irq

/* File: bench/cfil_fifo_irq_chk.sv */
// Checker for the CAN FIFO interrupt block, bound to its top module.
// Assumes one mclk domain and the zero-wait APB slave of the design.
`timescale 1ns/10ps
module cfil_fifo_irq_chk (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        rst_n,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // FIFO and interrupts
   input wire logic        fifo_direction_transmit,
   input wire logic        fifo_full,
   input wire logic        fifo_half,
   input wire logic        fifo_empty,
   input wire logic        fifo_overflow,
   input wire logic        fifo_irq,
   input wire logic        irq
);
   // ==========================================
   // Shadow of enables and held overrun
   logic [6:0] en_reg;
   logic       ovr_reg;
   wire        dir = fifo_direction_transmit;
   wire        acc = psel & penable;
   wire        wr  = acc & pwrite;
   wire        nf  = dir & ~fifo_full;
   wire [6:0]  cnd = {nf, dir & fifo_half, dir & fifo_empty, ~dir & ovr_reg,
                      ~dir & fifo_full, ~dir & fifo_half, ~dir & ~fifo_empty};
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         en_reg  <= 7'h00;
         ovr_reg <= 1'b0;
      end else begin
         if (wr && paddr == cfil_pkg::OFS_ENABLE_STATUS) en_reg <= {pwdata[26:24], pwdata[19:16]};
         if (fifo_overflow) ovr_reg <= 1'b1;
         else if (wr && paddr == cfil_pkg::OFS_EVENT_STATUS && pwdata[19]) ovr_reg <= 1'b0;
      end
   end
   // ==========================================
   // Properties
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   property p_tx; |(cnd[6:4] & en_reg[6:4]) |-> fifo_irq; endproperty
   property p_rx; |(cnd[3:0] & en_reg[3:0]) |-> fifo_irq; endproperty
   property p_any; fifo_irq |-> |(cnd & en_reg); endproperty
   property p_nf; acc && !pwrite && paddr == 8'h00 |-> prdata[10] == $past(nf); endproperty
   property p_rsv; acc && !pwrite && paddr == 8'h00 |-> (prdata & 32'hf8f0f800) == 32'h0; endproperty
   property p_rdy; pready == acc; endproperty
   property p_err; acc && !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c}) |-> pslverr; endproperty
   property p_mask; wr && paddr == 8'h08 && pwdata == 32'h0 |=> !irq ##1 !irq; endproperty
   a_tx: assert property (p_tx) else $error("tx condition enabled but no fifo_irq");
   a_rx: assert property (p_rx) else $error("rx condition enabled but no fifo_irq");
   a_any: assert property (p_any) else $error("fifo_irq without enabled condition");
   a_nf: assert property (p_nf) else $error("not-full flag wrong");
   a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
   a_rdy: assert property (p_rdy) else $error("pready not in access phase");
   a_err: assert property (p_err) else $error("unmapped access without pslverr");
   a_mask: assert property (p_mask) else $error("irq while fully masked");
   c_fifo_irq: cover property ($rose(fifo_irq));
   c_irq: cover property ($rose(irq));
   c_err: cover property (pslverr);
endmodule // cfil_fifo_irq_chk

bind cfil_fifo_irq cfil_fifo_irq_chk chk_u (.mclk(mclk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .fifo_direction_transmit(fifo_direction_transmit),
   .fifo_full(fifo_full), .fifo_half(fifo_half), .fifo_empty(fifo_empty),
   .fifo_overflow(fifo_overflow), .fifo_irq(fifo_irq), .irq(irq));

/* File: bench/cfil_tb.sv */
// Self-checking bench for the CAN FIFO interrupt block with a reference model.
// Assumes the zero-wait APB slave and the register map of the design package.
`timescale 1ns/10ps
module testbench;
   logic        mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic        pready, pslverr, fifo_irq, irq;
   logic        dir = 1'b0, ful = 1'b0, hlf = 1'b0, emp = 1'b1, ovf = 1'b0;
   logic [6:0]  m_en, m_st, m_msk, m_prev;
   logic        m_ovr;
   int          errors = 0, checks = 0, seed = 32'h6863e811;
   wire         wr = psel & penable & pwrite;
   wire [6:0]   cnd = {dir & ~ful, dir & hlf, dir & emp, ~dir & m_ovr,
                       ~dir & ful, ~dir & hlf, ~dir & ~emp};

   cfil_fifo_irq dut_u (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .fifo_direction_transmit(dir), .fifo_full(ful), .fifo_half(hlf),
      .fifo_empty(emp), .fifo_overflow(ovf), .fifo_irq(fifo_irq), .irq(irq));

   always #25 mclk = ~mclk;

   function automatic logic [6:0] pk(input logic [31:0] d);
      return {d[26:24], d[19:16]};
   endfunction
   function automatic logic [31:0] sp(input logic [6:0] v);
      return {5'h0, v[6:4], 4'h0, v[3:0], 16'h0};
   endfunction
   function automatic logic [31:0] expv(input logic [7:0] a);
      case (a)
         8'h00: return sp(m_en) | {21'h0, dir & ~ful, 10'h0};
         8'h04: return sp(m_st);
         8'h08: return sp(m_msk);
         default: return sp(cnd);
      endcase
   endfunction

   // ==========================================
   // Reference model
   always @(posedge mclk) begin
      if (!rst_n) begin
         {m_en, m_st, m_msk, m_prev, m_ovr} <= 29'h0;
      end else begin
         if (ovf) m_ovr <= 1'b1;
         else if (wr && paddr == 8'h04 && pwdata[19]) m_ovr <= 1'b0;
         m_prev <= cnd;
         m_st <= (m_st & ~((wr && paddr == 8'h04) ? pk(pwdata) : 7'h0)) | (cnd & ~m_prev);
         if (wr && paddr == 8'h00) m_en <= pk(pwdata);
         if (wr && paddr == 8'h08) m_msk <= pk(pwdata);
      end
   end

   always @(negedge mclk) begin
      if (rst_n) begin
         chk({31'h0, |(cnd & m_en)}, {31'h0, fifo_irq});
         chk({31'h0, |(m_st & m_msk)}, {31'h0, irq});
      end
   end

   // ==========================================
   // Tasks
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      logic [31:0] e;
      logic mapped;
      mapped = a inside {8'h00, 8'h04, 8'h08, 8'h0c};
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      #1 e = expv(a);
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         errors++;
         disable run.seq;
      end
      if (!w && mapped) chk(e, prdata);
      chk({31'h0, !mapped}, {31'h0, pslverr});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   task results;
      if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // ==========================================
   // Sequence
   initial begin : run
      begin : seq
         repeat (20) @(posedge mclk);
         rst_n <= 1'b1;
         @(posedge mclk);
         for (int i = 0; i < 5; i++) apb(1'b0, 8'(i * 4), 32'h0);
         apb(1'b1, 8'h00, 32'hffffffff);
         apb(1'b0, 8'h00, 32'h0);
         for (int i = 0; i < 7; i++) begin
            apb(1'b1, 8'h00, sp(7'h01 << i));
            for (int k = 0; k < 16; k++) begin
               {dir, ful, hlf, emp} <= 4'(k);
               apb(1'b0, 8'h00, 32'h0);
            end
         end
         dir <= 1'b0;
         apb(1'b1, 8'h00, sp(7'h08));
         ovf <= 1'b1;
         @(posedge mclk);
         ovf <= 1'b0;
         apb(1'b0, 8'h04, 32'h0);
         apb(1'b1, 8'h04, 32'h00080000);
         apb(1'b0, 8'h0c, 32'h0);
         apb(1'b1, 8'h08, 32'hffffffff);
         for (int i = 0; i < 400; i++) begin
            r = $random(seed);
            {dir, ful, hlf, emp, ovf} <= r[4:0];
            @(posedge mclk);
            if (r[5]) begin
               ovf <= 1'b0;
               apb(r[6], {3'h0, r[9:7], 2'h0}, $random(seed));
            end
         end
         ovf <= 1'b0;
         apb(1'b1, 8'h08, 32'h0);
         apb(1'b1, 8'h04, 32'hffffffff);
         apb(1'b0, 8'h04, 32'h0);
      end
      results();
   end
endmodule // testbench
